/* common/sram_pkg.sv */
// shared widths, levels, states and carriers for the burst static memory
// assumes every file reaches these names through sram_pkg:: scoping
package sram_pkg;

  // ---------------------------------------------------------------
  // array shape
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 16;
  localparam int DEPTH   = 65536;
  localparam int LANES   = 4;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int BASE_W  = ADDR_W - BURST_W;

  // ---------------------------------------------------------------
  // constant values
  // ---------------------------------------------------------------
  localparam logic [LANES-1:0]   LANES_ALL  = 4'hF;
  localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [BASE_W-1:0]  BASE_ZERO  = 14'h0;
  localparam logic [DATA_W-1:0]  DATA_ZERO  = 36'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {ST_DESEL, ST_BURST} state_t;

  // synchronous controls as sampled on one edge, all active low
  typedef struct packed {
    logic             proc_stb_n;
    logic             ctrl_stb_n;
    logic             adv_n;
    logic             gw_n;
    logic             bwg_n;
    logic [LANES-1:0] lane_n;
  } ctl_t;

endpackage

/* hdl/sram_lanes.sv */
// storage array, one memory per byte lane with its own write enable
// assumes write address and data are stable at the clock edge
`timescale 1ns/1ps
module sram_lanes (
  input  wire logic                         clock,
  input  wire logic [sram_pkg::LANES-1:0]   we,
  input  wire logic [sram_pkg::ADDR_W-1:0]  wr_addr,
  input  wire logic [sram_pkg::DATA_W-1:0]  wr_data,
  input  wire logic [sram_pkg::ADDR_W-1:0]  rd_addr,
  output logic      [sram_pkg::DATA_W-1:0]  rd_data
);

  // ---------------------------------------------------------------
  // lanes
  // ---------------------------------------------------------------
  // separate arrays per lane keep one driver per variable
  genvar g;
  generate
    for (g = 0; g < sram_pkg::LANES; g = g + 1) begin : g_lane
      logic [sram_pkg::LANE_W-1:0] mem [sram_pkg::DEPTH];

      always_ff @(posedge clock) begin
        if (we[g]) begin
          mem[wr_addr] <= wr_data[g*sram_pkg::LANE_W +: sram_pkg::LANE_W];
        end
      end

      assign rd_data[g*sram_pkg::LANE_W +: sram_pkg::LANE_W] = mem[rd_addr];
    end
  endgenerate

endmodule

/* hdl/burst_seq.sv */
// two-bit burst offset generator, interleaved or linear order
// assumes load and advance are never asked for on the same edge
`timescale 1ns/1ps
module burst_seq (
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic                          load,
  input  wire logic [sram_pkg::BURST_W-1:0]  start,
  input  wire logic                          advance,
  input  wire logic                          linear,
  output logic      [sram_pkg::BURST_W-1:0]  lsb
);

  logic [sram_pkg::BURST_W-1:0] start_r, start_nxt;
  logic [sram_pkg::BURST_W-1:0] count_r, count_nxt;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_comb begin
    start_nxt = start_r;
    count_nxt = count_r;
    if (load) begin
      start_nxt = start;
      count_nxt = sram_pkg::BURST_ZERO;
    end else if (advance) begin
      count_nxt = count_r + sram_pkg::BURST_STEP;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      start_r <= sram_pkg::BURST_ZERO;
      count_r <= sram_pkg::BURST_ZERO;
    end else begin
      start_r <= start_nxt;
      count_r <= count_nxt;
    end
  end

  // wraps inside the four-word group in both orders
  assign lsb = linear ? start_r + count_r : start_r ^ count_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_linear_step:
  assert property (@(posedge clock) disable iff (sys_rst)
    advance && !load && linear ##1 linear |->
      lsb == $past(lsb) + sram_pkg::BURST_STEP)
    else $error("linear burst did not step by one");

  a_xor_order:
  assert property (@(posedge clock) disable iff (sys_rst)
    advance && !load && !linear ##1 !linear |->
      (lsb ^ start_r) == $past(count_r) + sram_pkg::BURST_STEP)
    else $error("interleaved burst order broken");

endmodule

/* hdl/burst_sram.sv */
// synchronous burst static memory, 64K words of 36 bits, pipelined
// assumes all synchronous inputs meet setup to clock; the output
// enable, flow-through, count order and sleep pins are static or async
`timescale 1ns/1ps
module burst_sram (
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  input  wire logic [sram_pkg::ADDR_W-1:0]  addr,
  input  wire logic [sram_pkg::DATA_W-1:0]  dq_in,
  output logic      [sram_pkg::DATA_W-1:0]  dq_out,
  output logic                              dq_oe,
  input  wire logic                         processor_address_strobe_n,
  input  wire logic                         controller_address_strobe_n,
  input  wire logic                         burst_advance_n,
  input  wire logic                         global_write_all_n,
  input  wire logic                         byte_write_gate_n,
  input  wire logic [sram_pkg::LANES-1:0]   lane_write_select_n,
  input  wire logic                         master_chip_select_n,
  input  wire logic                         secondary_select_high,
  input  wire logic                         secondary_select_low_n,
  input  wire logic                         output_enable_n,
  input  wire logic                         count_order_select,
  input  wire logic                         flow_through_select_n,
  input  wire logic                         sleep_request
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sram_pkg::ctl_t                ctl;
  logic                          cs_ok;
  logic                          proc_start;
  logic                          ctrl_start;
  logic                          any_start;
  logic                          sel_start;
  logic                          wr_start;
  logic                          desel;
  logic                          cont;
  logic [sram_pkg::LANES-1:0]    lane_req;
  logic [sram_pkg::LANES-1:0]    lane_we;
  logic                          write_any;
  logic                          advance;
  logic [sram_pkg::BURST_W-1:0]  lsb;
  logic [sram_pkg::ADDR_W-1:0]   cur_addr;
  logic [sram_pkg::ADDR_W-1:0]   wr_addr;
  logic [sram_pkg::DATA_W-1:0]   rd_data;
  sram_pkg::state_t              state_r, state_nxt;
  logic [sram_pkg::BASE_W-1:0]   base_r, base_nxt;
  logic                          read_r, read_nxt;
  logic                          drive_r, drive_nxt;
  logic [sram_pkg::DATA_W-1:0]   out_r, out_nxt;

  assign ctl = {processor_address_strobe_n, controller_address_strobe_n,
                burst_advance_n, global_write_all_n, byte_write_gate_n,
                lane_write_select_n};

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  always_comb begin
    // all three selects must agree before any strobe is honoured
    cs_ok = !master_chip_select_n && secondary_select_high &&
            !secondary_select_low_n;
    proc_start = !ctl.proc_stb_n && !master_chip_select_n;
    ctrl_start = !ctl.ctrl_stb_n && ctl.proc_stb_n;
    any_start  = proc_start || ctrl_start;
    // sleep freezes the whole control path
    sel_start  = any_start && cs_ok && !sleep_request;
    desel      = any_start && !cs_ok && !sleep_request;
    wr_start   = sel_start && ctrl_start;
    cont       = (state_r == sram_pkg::ST_BURST) && !any_start &&
                 !sleep_request;
  end

  // ---------------------------------------------------------------
  // lane write enables
  // ---------------------------------------------------------------
  always_comb begin
    if (!ctl.gw_n) begin
      lane_req = sram_pkg::LANES_ALL;
    end else if (!ctl.bwg_n) begin
      lane_req = ~ctl.lane_n;
    end else begin
      lane_req = sram_pkg::LANES_NONE;
    end
    // processor starts never reach here, so selects go unseen there
    lane_we = sram_pkg::LANES_NONE;
    if (wr_start || cont) begin
      lane_we = lane_req;
    end
    write_any = |lane_we;
    // controller writes land on the new address at once
    wr_addr = wr_start ? addr : cur_addr;
  end

  // ---------------------------------------------------------------
  // burst address
  // ---------------------------------------------------------------
  always_comb begin
    // both strobes high needed for a read step; a write only needs advance
    advance = cont && !ctl.adv_n &&
              (write_any || (ctl.proc_stb_n && ctl.ctrl_stb_n));
  end

  burst_seq u_seq (
    .clock   (clock),
    .sys_rst (sys_rst),
    .load    (sel_start),
    .start   (addr[sram_pkg::BURST_W-1:0]),
    .advance (advance),
    .linear  (!count_order_select),
    .lsb     (lsb)
  );

  assign cur_addr = {base_r, lsb};

  // ---------------------------------------------------------------
  // array
  // ---------------------------------------------------------------
  sram_lanes u_mem (
    .clock   (clock),
    .we      (lane_we),
    .wr_addr (wr_addr),
    .wr_data (dq_in),
    .rd_addr (cur_addr),
    .rd_data (rd_data)
  );

  // ---------------------------------------------------------------
  // pipeline control
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    base_nxt  = base_r;
    read_nxt  = read_r;
    drive_nxt = drive_r;
    out_nxt   = out_r;
    if (!sleep_request) begin
      if (desel) begin
        // single-cycle deselect, both stages dropped together
        state_nxt = sram_pkg::ST_DESEL;
        read_nxt  = 1'h0;
        drive_nxt = 1'h0;
      end else begin
        if (sel_start) begin
          state_nxt = sram_pkg::ST_BURST;
          base_nxt  = addr[sram_pkg::ADDR_W-1:sram_pkg::BURST_W];
        end
        if (sel_start || cont) begin
          read_nxt = !write_any;
        end
        drive_nxt = read_r && !write_any;
        if (read_r) begin
          out_nxt = rd_data;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= sram_pkg::ST_DESEL;
      base_r  <= sram_pkg::BASE_ZERO;
      read_r  <= 1'h0;
      drive_r <= 1'h0;
      out_r   <= sram_pkg::DATA_ZERO;
    end else begin
      state_r <= state_nxt;
      base_r  <= base_nxt;
      read_r  <= read_nxt;
      drive_r <= drive_nxt;
      out_r   <= out_nxt;
    end
  end

  // ---------------------------------------------------------------
  // data pins
  // ---------------------------------------------------------------
  // flow-through skips the output register, trading access time for
  // one cycle less latency
  assign dq_out = flow_through_select_n ? out_r : rd_data;
  // output enable acts straight on the drivers, no register on it
  assign dq_oe = !output_enable_n && !sleep_request &&
                 (flow_through_select_n ? drive_r : read_r);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_proc_read:
  assert property (@(posedge clock) disable iff (sys_rst)
    proc_start |-> lane_we == sram_pkg::LANES_NONE)
    else $error("processor strobe edge wrote the array");

  a_addr_load:
  assert property (@(posedge clock) disable iff (sys_rst)
    sel_start |=> cur_addr == $past(addr))
    else $error("start edge did not load the address");

  a_pipe_data:
  assert property (@(posedge clock) disable iff (sys_rst)
    sel_start && proc_start ##1
      (!any_start && lane_req == sram_pkg::LANES_NONE && !sleep_request)
      |=> out_r == $past(rd_data) && drive_r)
    else $error("pipelined read data not registered");

  a_adv_ignored:
  assert property (@(posedge clock) disable iff (sys_rst)
    sel_start && !ctl.adv_n |=> lsb == $past(addr[sram_pkg::BURST_W-1:0]))
    else $error("advance acted on a start edge");

  a_read_step:
  assert property (@(posedge clock) disable iff (sys_rst)
    cont && !write_any && !ctl.adv_n && ctl.proc_stb_n &&
      ctl.ctrl_stb_n |=> lsb != $past(lsb))
    else $error("read burst did not step");

  a_global_write:
  assert property (@(posedge clock) disable iff (sys_rst)
    (cont || wr_start) && !ctl.gw_n |->
      lane_we == sram_pkg::LANES_ALL)
    else $error("global write missed a lane");

  a_gate_closed:
  assert property (@(posedge clock) disable iff (sys_rst)
    ctl.gw_n && ctl.bwg_n |-> lane_we == sram_pkg::LANES_NONE)
    else $error("lane written with byte gate high");

  a_write_quiet:
  assert property (@(posedge clock) disable iff (sys_rst)
    write_any |=> !dq_oe)
    else $error("drivers on after a sampled write");

  a_base_hold:
  assert property (@(posedge clock) disable iff (sys_rst)
    advance |=> base_r == $past(base_r))
    else $error("burst changed the upper address");

  a_desel_one:
  assert property (@(posedge clock) disable iff (sys_rst)
    desel |-> lane_we == sram_pkg::LANES_NONE ##1
      (!dq_oe && state_r == sram_pkg::ST_DESEL))
    else $error("deselect took more than one cycle");

  a_sleep_quiet:
  assert property (@(posedge clock) disable iff (sys_rst)
    sleep_request |-> !dq_oe && lane_we == sram_pkg::LANES_NONE)
    else $error("activity during sleep");

  a_oe_gate:
  assert property (@(posedge clock) disable iff (sys_rst)
    output_enable_n |-> !dq_oe)
    else $error("drivers on with output enable high");

  a_flow_path:
  assert property (@(posedge clock) disable iff (sys_rst)
    !flow_through_select_n |-> dq_out == rd_data)
    else $error("flow-through did not bypass the register");

  a_select_gate:
  assert property (@(posedge clock) disable iff (sys_rst)
    any_start && !cs_ok |-> lane_we == sram_pkg::LANES_NONE)
    else $error("unselected strobe wrote the array");

  a_idle_hold:
  assert property (@(posedge clock) disable iff (sys_rst)
    state_r == sram_pkg::ST_DESEL && !sel_start |=>
      state_r == sram_pkg::ST_DESEL && !read_r)
    else $error("burst began without a strobe");

  a_lane_skip:
  assert property (@(posedge clock) disable iff (sys_rst)
    proc_start && cs_ok && !sleep_request &&
      ctl.lane_n != sram_pkg::LANES_ALL |=> read_r)
    else $error("lane select honoured on processor start");

  a_lane_mask:
  assert property (@(posedge clock) disable iff (sys_rst)
    (cont || wr_start) && ctl.gw_n && !ctl.bwg_n |->
      lane_we == ~ctl.lane_n)
    else $error("lane write mask wrong");

  a_write_step:
  assert property (@(posedge clock) disable iff (sys_rst)
    cont && write_any && !ctl.adv_n |=> lsb != $past(lsb))
    else $error("write burst did not step");

  a_ctrl_write:
  assert property (@(posedge clock) disable iff (sys_rst)
    wr_start && !ctl.gw_n |->
      lane_we == sram_pkg::LANES_ALL && wr_addr == addr)
    else $error("controller start write missed");

  a_ctrl_read:
  assert property (@(posedge clock) disable iff (sys_rst)
    wr_start && lane_req == sram_pkg::LANES_NONE |=>
      read_r && cur_addr == $past(addr))
    else $error("controller start read missed");

  a_proc_block:
  assert property (@(posedge clock) disable iff (sys_rst)
    !ctl.proc_stb_n && master_chip_select_n && !sleep_request &&
      state_r == sram_pkg::ST_BURST |=> base_r == $past(base_r))
    else $error("blocked processor strobe loaded an address");

  a_desel_quiet:
  assert property (@(posedge clock) disable iff (sys_rst)
    state_r == sram_pkg::ST_DESEL |-> !dq_oe)
    else $error("drivers on while deselected");

  a_flow_drive:
  assert property (@(posedge clock) disable iff (sys_rst)
    !flow_through_select_n && !output_enable_n && !sleep_request &&
      read_r |-> dq_oe)
    else $error("flow-through read not driven");

endmodule

/* tb/bus_master.sv */
// bus master model: drives strobes, enables, address and write data
// assumes it is called once per cycle, 10 ns after the rising edge
`timescale 1ns/1ps
module bus_master (
  input  wire logic                         clock,
  output logic      [sram_pkg::ADDR_W-1:0]  addr,
  output logic      [sram_pkg::DATA_W-1:0]  dq_in,
  output logic                              proc_n,
  output logic                              ctrl_n,
  output logic                              adv_n,
  output logic                              gw_n,
  output logic                              bwg_n,
  output logic      [sram_pkg::LANES-1:0]   lane_n,
  output logic                              oe_n
);
  // ---------------------------------------------------------------
  // one bus cycle
  // ---------------------------------------------------------------
  sram_pkg::ctl_t ctl;

  assign {proc_n, ctrl_n, adv_n, gw_n, bwg_n, lane_n} = ctl;

  initial begin
    ctl   = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF};
    addr  = 16'h0;
    dq_in = 36'h0;
    oe_n  = 1'h1;
  end

  // bad keeps the outputs enabled on a write, on purpose
  task automatic cyc(input sram_pkg::ctl_t c,
                     input logic [sram_pkg::ADDR_W-1:0] a,
                     input logic [sram_pkg::DATA_W-1:0] d,
                     input logic oe,
                     input logic bad);
    logic wr;
    wr   = !c.gw_n || (!c.bwg_n && (c.lane_n != 4'hF));
    ctl  = c;
    addr = a;
    oe_n = (wr && !bad) ? 1'h1 : oe;
    // a released data line shows the inverse, never a stale copy
    dq_in = wr ? d : ~dq_in;
    @(posedge clock);
    #10;
  endtask
endmodule

/* tb/test_burst_sram.sv */
// self-checking bench for the burst static memory
// assumes bus_master drives the bus; static pins driven here
`timescale 1ns/1ps
module test_burst_sram;
  // ---------------------------------------------------------------
  // cycle kinds: proc, ctrl, adv, gw, gate, lanes
  // ---------------------------------------------------------------
  localparam sram_pkg::ctl_t IDL  = '{1'h1,1'h1,1'h1,1'h1,1'h1,4'hF};
  localparam sram_pkg::ctl_t BURST_ADVANCE  = '{1'h1,1'h1,1'h0,1'h1,1'h1,4'hF};
  localparam sram_pkg::ctl_t RDP  = '{1'h0,1'h1,1'h1,1'h1,1'h1,4'hF};
  localparam sram_pkg::ctl_t WRC  = '{1'h1,1'h0,1'h1,1'h0,1'h1,4'hF};
  localparam sram_pkg::ctl_t RDC  = '{1'h1,1'h0,1'h1,1'h1,1'h1,4'hF};
  localparam sram_pkg::ctl_t WRA  = '{1'h1,1'h1,1'h0,1'h0,1'h1,4'hF};
  localparam sram_pkg::ctl_t PBAD = '{1'h0,1'h0,1'h0,1'h0,1'h0,4'h0};
  localparam sram_pkg::ctl_t BYT  = '{1'h1,1'h1,1'h1,1'h1,1'h0,4'h6};
  localparam sram_pkg::ctl_t GOFF = '{1'h1,1'h1,1'h1,1'h1,1'h1,4'h0};

  logic                        clock;
  logic                        sys_rst;
  logic [sram_pkg::ADDR_W-1:0] addr;
  logic [sram_pkg::DATA_W-1:0] dq_in;
  logic [sram_pkg::DATA_W-1:0] dq_out;
  logic                        dq_oe;
  logic                        proc_n;
  logic                        ctrl_n;
  logic                        adv_n;
  logic                        gw_n;
  logic                        bwg_n;
  logic [sram_pkg::LANES-1:0]  lane_n;
  logic                        oe_n;
  logic                        msel_n;
  logic                        sel_hi;
  logic                        sel_lo_n;
  logic                        order;
  logic                        ft_n;
  logic                        sleep;
  int                          errors;
  int                          tests_run;
  logic [sram_pkg::DATA_W-1:0] exp_mem [logic [sram_pkg::ADDR_W-1:0]];

  burst_sram u_burst_sram (.clock(clock), .sys_rst(sys_rst), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .processor_address_strobe_n(proc_n),
    .controller_address_strobe_n(ctrl_n), .burst_advance_n(adv_n),
    .global_write_all_n(gw_n), .byte_write_gate_n(bwg_n),
    .lane_write_select_n(lane_n), .master_chip_select_n(msel_n),
    .secondary_select_high(sel_hi), .secondary_select_low_n(sel_lo_n),
    .output_enable_n(oe_n), .count_order_select(order),
    .flow_through_select_n(ft_n), .sleep_request(sleep));

  bus_master u_bus_master (.clock(clock), .addr(addr), .dq_in(dq_in),
    .proc_n(proc_n), .ctrl_n(ctrl_n), .adv_n(adv_n), .gw_n(gw_n),
    .bwg_n(bwg_n), .lane_n(lane_n), .oe_n(oe_n));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] lsb(input logic [1:0] s, input int k,
                                     input logic lin);
    return lin ? s + 2'(k) : s ^ 2'(k);
  endfunction

  function automatic logic [35:0] pat(input logic [15:0] a,
                                      input logic [3:0] salt);
    return {salt, a, ~a};
  endfunction

  task automatic chk(input logic [35:0] got, input logic [35:0] want,
                     input string msg);
    tests_run++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr_burst(input logic [15:0] a, input logic lin,
                          input logic [3:0] salt);
    logic [15:0] b;
    order = !lin;
    u_bus_master.cyc(WRC, a, pat(a, salt), 1'h0, 1'h0);
    exp_mem[a] = pat(a, salt);
    for (int k = 0; k < 4; k++) begin
      b = {a[15:2], lsb(a[1:0], k, lin)};
      u_bus_master.cyc(WRA, ~a, pat(b, salt), 1'h0, 1'h0);
      exp_mem[b] = pat(b, salt);
    end
  endtask

  task automatic rd_burst(input logic [15:0] a, input logic lin);
    order = !lin;
    u_bus_master.cyc(RDP, a, 36'h0, 1'h0, 1'h0);
    for (int k = 0; k < 4; k++) begin
      u_bus_master.cyc(BURST_ADVANCE, ~a, 36'h0, 1'h0, 1'h0);
      chk(dq_out, exp_mem[{a[15:2], lsb(a[1:0], k, lin)}], "burst");
      chk(dq_oe, 1'h1, "burst enable");
    end
  endtask

  task automatic rd_one(input logic [15:0] a);
    u_bus_master.cyc(RDP, a, 36'h0, 1'h0, 1'h0);
    u_bus_master.cyc(IDL, ~a, 36'h0, 1'h0, 1'h0);
    chk(dq_out, exp_mem[a], "single read");
    chk(dq_oe, 1'h1, "single enable");
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  initial begin
    #100000;
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    sys_rst = 1'h1;
    {msel_n, sel_hi, sel_lo_n} = 3'h2;
    {order, ft_n, sleep} = 3'h6;
    repeat (5) @(posedge clock);
    #10;
    sys_rst = 1'h0;
    chk(dq_oe, 1'h0, "reset enable");
    chk(dq_out, 36'h0, "reset data");
    wr_burst(16'h1232, 1'h1, 4'h5);
    rd_burst(16'h1231, 1'h0);
    rd_burst(16'h1233, 1'h1);
    // processor start ignores every write enable and advance
    u_bus_master.cyc(WRC, 16'h0040, pat(16'h0040, 4'h1), 1'h0, 1'h0);
    exp_mem[16'h0040] = pat(16'h0040, 4'h1);
    u_bus_master.cyc(PBAD, 16'h0040, 36'h0, 1'h0, 1'h0);
    u_bus_master.cyc(IDL, 16'hFFBF, 36'h0, 1'h0, 1'h0);
    chk(dq_out, exp_mem[16'h0040], "start ignores writes");
    u_bus_master.cyc(BYT, 16'hFFBF, 36'hFFFFFFFFF, 1'h0, 1'h1);
    chk(dq_oe, 1'h0, "lane write drivers");
    exp_mem[16'h0040] = exp_mem[16'h0040] | 36'hFF80001FF;
    u_bus_master.cyc(GOFF, 16'hFFBF, 36'h0, 1'h0, 1'h0);
    rd_one(16'h0040);
    ft_n = 1'h0;
    u_bus_master.cyc(RDP, 16'h0040, 36'h0, 1'h0, 1'h0);
    chk(dq_out, exp_mem[16'h0040], "flow data");
    chk(dq_oe, 1'h1, "flow enable");
    ft_n = 1'h1;
    u_bus_master.cyc(RDC, 16'h1232, 36'h0, 1'h0, 1'h0);
    u_bus_master.cyc(IDL, 16'hEDCD, 36'h0, 1'h0, 1'h0);
    chk(dq_out, exp_mem[16'h1232], "controller read");
    chk(dq_oe, 1'h1, "controller enable");
    rd_one(16'h1230);
    u_bus_master.cyc(IDL, 16'hEDCF, 36'h0, 1'h1, 1'h0);
    chk(dq_oe, 1'h0, "output enable off");
    u_bus_master.cyc(IDL, 16'hEDCF, 36'h0, 1'h0, 1'h0);
    chk(dq_out, exp_mem[16'h1230], "output enable on");
    chk(dq_oe, 1'h1, "output enable back");
    sleep = 1'h1;
    u_bus_master.cyc(IDL, 16'hEDCF, 36'h0, 1'h0, 1'h0);
    chk(dq_oe, 1'h0, "sleep enable");
    u_bus_master.cyc(WRC, 16'h1230, 36'h0, 1'h0, 1'h0);
    sleep = 1'h0;
    rd_one(16'h1230);
    // each select off in turn: no write, outputs stay off
    for (int i = 0; i < 3; i++) begin
      rd_one(16'h1231);
      {msel_n, sel_hi, sel_lo_n} = {i == 0, i != 1, i == 2};
      u_bus_master.cyc(WRC, 16'h1231, 36'h0, 1'h0, 1'h1);
      {msel_n, sel_hi, sel_lo_n} = 3'h2;
      u_bus_master.cyc(IDL, 16'hEDCE, 36'h0, 1'h0, 1'h0);
      chk(dq_oe, 1'h0, "deselect enable");
      rd_one(16'h1231);
    end
    // a blocked processor strobe only continues the running burst
    msel_n = 1'h1;
    u_bus_master.cyc(RDP, 16'h0040, 36'h0, 1'h0, 1'h0);
    msel_n = 1'h0;
    u_bus_master.cyc(IDL, 16'hFFBF, 36'h0, 1'h0, 1'h0);
    chk(dq_out, exp_mem[16'h1231], "blocked strobe");
    chk(dq_oe, 1'h1, "blocked enable");
    close_out();
  end
endmodule
